/* File: design/ict_pkg.sv */
// How it works
// - track clocks, reads and writes per instruction
// - add address time where entry is additive
// - clear/invert ops: register 4/6, memory 8/12
// - decimal negate, test-set, zero compare figures
// - set on condition depends on outcome in register form only
// - register shifts take 6+2n or 8+2n
// - memory shifts word only, 8 clocks
// - dynamic bit ops figures
// - static bit ops figures
// - register bit changes need data register
// - conditional branch taken versus not taken
// - goto, call, bounds check, overflow trap
// - decrement and branch three outcomes
// - jump and call by addressing mode
// - load and push address by mode
// - multi transfer memory to registers
// - multi transfer registers to memory
// - index size does not change timing
package ict_pkg;
    ////////////////////////////////////////////////////////////////////////
    // widths and bus cycle timing
    localparam int CLK_W = 10; // total clock figure width
    localparam int CNT_W = 6; // read or write count width
    localparam logic [1:0] BUS_LAST_PH = 2'h3; // four clocks per bus cycle
    localparam int BUS_SHIFT = 2; // bus clocks = cycles times four
    localparam logic [CLK_W-1:0] CLK_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 6'h01;

    ////////////////////////////////////////////////////////////////////////
    // instruction classes handled here
    typedef enum logic [4:0] {
        OP_CLEAR = 5'h00, OP_INV = 5'h01, OP_INVX = 5'h02, OP_BNOT = 5'h03,
        OP_DECNEG = 5'h04, OP_SETCOND = 5'h05, OP_TESTSET = 5'h06,
        OP_TOZERO = 5'h07, OP_ASHIFT = 5'h08, OP_LSHIFT = 5'h09,
        OP_ROT = 5'h0a, OP_ROTX = 5'h0b, OP_BTOG = 5'h0c, OP_BIT_CLEAR = 5'h0d,
        OP_BIT_SET = 5'h0e, OP_BTEST = 5'h0f, OP_CONDBR = 5'h10,
        OP_GOTO = 5'h11, OP_CALLREL = 5'h12, OP_BOUNDS = 5'h13,
        OP_OVFTRAP = 5'h14, OP_DECBR = 5'h15, OP_JUMP = 5'h16,
        OP_CALLABS = 5'h17, OP_LOADEA = 5'h18, OP_PUSHEA = 5'h19,
        OP_MREG_LD = 5'h1a, OP_MREG_ST = 5'h1b
    } ict_op_t;

    // operand size
    typedef enum logic [1:0] {SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2} ict_size_t;

    // control addressing modes; displacement, short absolute and pc
    // relative share one timing class, both index forms share another
    typedef enum logic [2:0] {
        AM_IND = 3'h0, AM_POST = 3'h1, AM_PRE = 3'h2, AM_DISP = 3'h3,
        AM_INDEX = 3'h4, AM_ABSL = 3'h5
    } ict_am_t;

    // sequencer states, one-hot
    typedef enum logic [2:0] {ST_IDLE = 3'h1, ST_BUS = 3'h2, ST_INT = 3'h4} ict_state_t;
endpackage

/* File: design/ict_cnt.sv */
`timescale 1ns/1ps
// loadable down counter with zero flag
module ict_cnt #(
    parameter int W = 6
) (
    input wire logic clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic dec,
    output logic [W-1:0] count,
    output logic zero
);
    typedef struct packed {
        logic [W-1:0] cnt; // remaining units
    } ict_cnt_state_t;

    ict_cnt_state_t s_reg;
    ict_cnt_state_t s_next;

    // load wins over decrement; decrement at zero holds
    always_comb begin
        s_next = s_reg;
        if (load) begin
            s_next.cnt = load_val;
        end else if (dec && s_reg.cnt != '0) begin
            s_next.cnt = s_reg.cnt - W'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign count = s_reg.cnt;
    assign zero = (s_reg.cnt == '0);
endmodule

/* File: design/ict_core.sv */
`timescale 1ns/1ps
// instruction cycle timing sequencer
module ict_core (
    input wire logic clk,
    input wire logic srst,
    input wire logic start, // take one instruction while idle
    input wire ict_pkg::ict_op_t op, // instruction class
    input wire ict_pkg::ict_size_t size, // operand size
    input wire logic mem_operand, // operand in memory, else register
    input wire logic addr_reg_target, // register form names an address reg
    input wire logic cond_true, // condition or branch outcome
    input wire logic count_expired, // loop counter ran out
    input wire logic disp_word, // word displacement, else byte
    input wire logic bit_static, // bit number from extension word
    input wire ict_pkg::ict_am_t amode, // control addressing mode
    input wire logic [5:0] shift_cnt, // shift count n
    input wire logic [4:0] reg_cnt, // registers moved n
    input wire logic [7:0] ea_clk, // address calculation clocks
    input wire logic [3:0] ea_rd, // address calculation reads
    input wire logic [3:0] ea_wr, // address calculation writes
    input wire logic bus_ready, // partner ends bus cycle this clock
    output logic busy,
    output logic done, // one-cycle pulse after last clock
    output logic fault, // illegal form refused
    output logic bus_rd, // read cycle in progress
    output logic bus_wr, // write cycle in progress
    output logic [9:0] tot_clk,
    output logic [5:0] tot_rd,
    output logic [5:0] tot_wr
);
    ////////////////////////////////////////////////////////////////////////
    // state
    typedef struct packed {
        ict_pkg::ict_state_t st;
        logic [1:0] ph; // clock within bus cycle
        logic busy;
        logic done;
        logic fault;
        logic bus_rd;
        logic bus_wr;
        logic [9:0] tot_clk;
        logic [5:0] tot_rd;
        logic [5:0] tot_wr;
        logic [9:0] seen_clk; // busy cycles since take, checking only
        logic [9:0] seen_wait; // wait states since take, checking only
        logic [5:0] seen_rd; // finished reads, checking only
        logic [5:0] seen_wr; // finished writes, checking only
    } ict_core_state_t;

    localparam ict_core_state_t RESET_S = '{st: ict_pkg::ST_IDLE, default: '0};

    ict_core_state_t s_reg;
    ict_core_state_t s_next;

    logic [21:0] lk; // {clocks, reads, writes} of the base entry
    logic lk_add; // entry needs address time added
    logic lk_bad; // form does not exist
    logic [9:0] t_clk;
    logic [5:0] t_rd;
    logic [5:0] t_wr;
    logic [9:0] t_int; // clocks left after the bus cycles
    logic take;
    logic rd_dec;
    logic wr_dec;
    logic [5:0] rd_left;
    logic [5:0] wr_left;
    logic [9:0] int_left;
    logic rd_zero;
    logic wr_zero;
    logic int_zero;
    logic bus_end; // bus cycle finishes this clock
    logic last_bus;
    logic is_long;

    function automatic logic [21:0] fig(logic [9:0] c, logic [5:0] r, logic [5:0] w);
        fig = {c, r, w};
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // base figure lookup, every figure includes the next fetch
    always_comb begin
        is_long = (size == ict_pkg::SZ_LONG);
        lk = fig(10'h004, 6'h01, 6'h00);
        lk_add = mem_operand;
        lk_bad = 1'b0;
        unique case (op)
            ict_pkg::OP_CLEAR, ict_pkg::OP_INV, ict_pkg::OP_INVX, ict_pkg::OP_BNOT: begin
                if (mem_operand) begin
                    lk = is_long ? fig(10'h00c, 6'h01, 6'h02) : fig(10'h008, 6'h01, 6'h01);
                end else begin
                    lk = is_long ? fig(10'h006, 6'h01, 6'h00) : fig(10'h004, 6'h01, 6'h00);
                end
            end
            ict_pkg::OP_DECNEG: begin
                lk = mem_operand ? fig(10'h008, 6'h01, 6'h01) : fig(10'h006, 6'h01, 6'h00);
            end
            ict_pkg::OP_TESTSET: begin
                lk = mem_operand ? fig(10'h00e, 6'h02, 6'h01) : fig(10'h004, 6'h01, 6'h00);
            end
            ict_pkg::OP_TOZERO: begin
                lk = fig(10'h004, 6'h01, 6'h00);
            end
            ict_pkg::OP_SETCOND: begin
                if (mem_operand) begin
                    lk = fig(10'h008, 6'h01, 6'h01);
                end else begin
                    lk = cond_true ? fig(10'h006, 6'h01, 6'h00) : fig(10'h004, 6'h01, 6'h00);
                end
            end
            ict_pkg::OP_ASHIFT, ict_pkg::OP_LSHIFT, ict_pkg::OP_ROT, ict_pkg::OP_ROTX: begin
                if (mem_operand) begin
                    // memory form shifts one word by one place only
                    lk = fig(10'h008, 6'h01, 6'h01);
                    lk_bad = (size != ict_pkg::SZ_WORD);
                end else begin
                    lk = fig((is_long ? 10'h008 : 10'h006) + {3'h0, shift_cnt, 1'b0},
                             6'h01, 6'h00);
                end
            end
            ict_pkg::OP_BTOG, ict_pkg::OP_BIT_SET, ict_pkg::OP_BIT_CLEAR, ict_pkg::OP_BTEST: begin
                if (mem_operand) begin
                    if (op == ict_pkg::OP_BTEST) begin
                        lk = bit_static ? fig(10'h008, 6'h02, 6'h00) : fig(10'h004, 6'h01, 6'h00);
                    end else begin
                        lk = bit_static ? fig(10'h00c, 6'h02, 6'h01) : fig(10'h008, 6'h01, 6'h01);
                    end
                end else begin
                    unique case (op)
                        ict_pkg::OP_BIT_CLEAR: lk = bit_static ? fig(10'h00e, 6'h02, 6'h00)
                                                          : fig(10'h00a, 6'h01, 6'h00);
                        ict_pkg::OP_BTEST: lk = bit_static ? fig(10'h00a, 6'h02, 6'h00)
                                                           : fig(10'h006, 6'h01, 6'h00);
                        default: lk = bit_static ? fig(10'h00c, 6'h02, 6'h00)
                                                 : fig(10'h008, 6'h01, 6'h00);
                    endcase
                    // bit change figures hold for data registers only; bit test also takes address registers
                    lk_bad = addr_reg_target && (op != ict_pkg::OP_BTEST);
                end
            end
            ict_pkg::OP_CONDBR: begin
                lk_add = 1'b0;
                if (cond_true) begin
                    lk = fig(10'h00a, 6'h02, 6'h00);
                end else begin
                    lk = disp_word ? fig(10'h00c, 6'h02, 6'h00) : fig(10'h008, 6'h01, 6'h00);
                end
            end
            ict_pkg::OP_GOTO: begin
                lk_add = 1'b0;
                lk = fig(10'h00a, 6'h02, 6'h00);
            end
            ict_pkg::OP_CALLREL: begin
                lk_add = 1'b0;
                lk = fig(10'h012, 6'h02, 6'h02);
            end
            ict_pkg::OP_BOUNDS: begin
                lk_add = 1'b1;
                lk = fig(10'h00a, 6'h01, 6'h00);
            end
            ict_pkg::OP_OVFTRAP: begin
                lk_add = 1'b0;
                lk = fig(10'h004, 6'h01, 6'h00);
            end
            ict_pkg::OP_DECBR: begin
                lk_add = 1'b0;
                if (cond_true) begin
                    lk = fig(10'h00c, 6'h02, 6'h00);
                end else begin
                    lk = count_expired ? fig(10'h00e, 6'h03, 6'h00) : fig(10'h00a, 6'h02, 6'h00);
                end
            end
            ict_pkg::OP_JUMP, ict_pkg::OP_CALLABS, ict_pkg::OP_LOADEA, ict_pkg::OP_PUSHEA: begin
                // address time is already folded into these entries;
                // both index forms share one row whatever the index size
                lk_add = 1'b0;
                lk_bad = (amode == ict_pkg::AM_POST) || (amode == ict_pkg::AM_PRE);
                unique case (op)
                    ict_pkg::OP_JUMP: lk = (amode == ict_pkg::AM_IND) ? fig(10'h008, 6'h02, 6'h00)
                        : (amode == ict_pkg::AM_INDEX) ? fig(10'h00e, 6'h03, 6'h00)
                        : (amode == ict_pkg::AM_ABSL) ? fig(10'h00c, 6'h03, 6'h00)
                        : fig(10'h00a, 6'h02, 6'h00);
                    ict_pkg::OP_CALLABS: lk = (amode == ict_pkg::AM_IND) ? fig(10'h010, 6'h02, 6'h02)
                        : (amode == ict_pkg::AM_INDEX) ? fig(10'h016, 6'h02, 6'h02)
                        : (amode == ict_pkg::AM_ABSL) ? fig(10'h014, 6'h03, 6'h02)
                        : fig(10'h012, 6'h02, 6'h02);
                    ict_pkg::OP_LOADEA: lk = (amode == ict_pkg::AM_IND) ? fig(10'h004, 6'h01, 6'h00)
                        : (amode == ict_pkg::AM_INDEX) ? fig(10'h00c, 6'h02, 6'h00)
                        : (amode == ict_pkg::AM_ABSL) ? fig(10'h00c, 6'h03, 6'h00)
                        : fig(10'h008, 6'h02, 6'h00);
                    default: lk = (amode == ict_pkg::AM_IND) ? fig(10'h00c, 6'h01, 6'h02)
                        : (amode == ict_pkg::AM_INDEX) ? fig(10'h014, 6'h02, 6'h02)
                        : (amode == ict_pkg::AM_ABSL) ? fig(10'h014, 6'h03, 6'h02)
                        : fig(10'h010, 6'h02, 6'h02);
                endcase
            end
            ict_pkg::OP_MREG_LD: begin
                lk_add = 1'b0;
                lk_bad = (amode == ict_pkg::AM_PRE);
                lk[21:12] = ((amode == ict_pkg::AM_DISP) ? 10'h010
                           : (amode == ict_pkg::AM_INDEX) ? 10'h012
                           : (amode == ict_pkg::AM_ABSL) ? 10'h014 : 10'h00c)
                           + (is_long ? {2'h0, reg_cnt, 3'h0} : {3'h0, reg_cnt, 2'h0});
                // long post-increment keeps its single-read-per-register count
                lk[11:6] = ((amode == ict_pkg::AM_DISP || amode == ict_pkg::AM_INDEX) ? 6'h04
                          : (amode == ict_pkg::AM_ABSL) ? 6'h05 : 6'h03)
                          + ((is_long && amode != ict_pkg::AM_POST) ? {reg_cnt, 1'b0}
                                                                     : {1'b0, reg_cnt});
                lk[5:0] = 6'h00;
            end
            ict_pkg::OP_MREG_ST: begin
                lk_add = 1'b0;
                lk_bad = (amode == ict_pkg::AM_POST);
                lk[21:12] = ((amode == ict_pkg::AM_DISP) ? 10'h00c
                           : (amode == ict_pkg::AM_INDEX) ? 10'h00e
                           : (amode == ict_pkg::AM_ABSL) ? 10'h010 : 10'h008)
                           + (is_long ? {2'h0, reg_cnt, 3'h0} : {3'h0, reg_cnt, 2'h0});
                lk[11:6] = (amode == ict_pkg::AM_DISP || amode == ict_pkg::AM_INDEX) ? 6'h03
                         : (amode == ict_pkg::AM_ABSL) ? 6'h04 : 6'h02;
                lk[5:0] = is_long ? {reg_cnt, 1'b0} : {1'b0, reg_cnt};
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // totals: base entry plus address calculation where additive
    always_comb begin
        t_clk = lk[21:12] + (lk_add ? {2'h0, ea_clk} : ict_pkg::CLK_ZERO);
        t_rd = lk[11:6] + (lk_add ? {2'h0, ea_rd} : 6'h00);
        t_wr = lk[5:0] + (lk_add ? {2'h0, ea_wr} : 6'h00);
        // every bus cycle is four clocks, the rest is internal work
        t_int = t_clk - ({4'h0, t_rd + t_wr} << ict_pkg::BUS_SHIFT);
    end

    ////////////////////////////////////////////////////////////////////////
    // remaining reads, writes and internal clocks
    assign take = s_reg.st[0] && start;
    assign bus_end = s_reg.st[1] && (s_reg.ph == ict_pkg::BUS_LAST_PH) && bus_ready;
    assign rd_dec = bus_end && !rd_zero; // reads run first
    assign wr_dec = bus_end && rd_zero && !wr_zero;
    assign last_bus = (rd_left == ict_pkg::CNT_ONE && wr_zero)
                   || (rd_zero && wr_left == ict_pkg::CNT_ONE);

    ict_cnt #(.W(6)) u_rd_left (.clk(clk), .srst(srst), .load(take), .load_val(t_rd),
        .dec(rd_dec), .count(rd_left), .zero(rd_zero));
    ict_cnt #(.W(6)) u_wr_left (.clk(clk), .srst(srst), .load(take), .load_val(t_wr),
        .dec(wr_dec), .count(wr_left), .zero(wr_zero));
    ict_cnt #(.W(10)) u_int_left (.clk(clk), .srst(srst), .load(take), .load_val(t_int),
        .dec(s_reg.st[2]), .count(int_left), .zero(int_zero));

    ////////////////////////////////////////////////////////////////////////
    // sequencer
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        if (s_reg.busy) begin
            s_next.seen_clk = s_reg.seen_clk + 10'h001;
        end
        unique case (s_reg.st)
            ict_pkg::ST_IDLE: begin
                if (take && lk_bad) begin
                    // unsupported form: refuse at once, no bus traffic
                    s_next.fault = 1'b1;
                    s_next.done = 1'b1;
                end else if (take) begin
                    s_next = RESET_S;
                    s_next.st = ict_pkg::ST_BUS;
                    s_next.busy = 1'b1;
                    s_next.bus_rd = 1'b1; // every form fetches, so a read comes first
                    s_next.tot_clk = t_clk;
                    s_next.tot_rd = t_rd;
                    s_next.tot_wr = t_wr;
                end
            end
            ict_pkg::ST_BUS: begin
                if (s_reg.ph != ict_pkg::BUS_LAST_PH) begin
                    s_next.ph = s_reg.ph + 2'h1;
                end else if (!bus_ready) begin
                    // wait state stretches the instruction, not the figures
                    s_next.seen_wait = s_reg.seen_wait + 10'h001;
                end else begin
                    s_next.ph = 2'h0;
                    s_next.seen_rd = s_reg.seen_rd + {5'h00, rd_dec};
                    s_next.seen_wr = s_reg.seen_wr + {5'h00, wr_dec};
                    s_next.bus_rd = rd_dec && (rd_left > ict_pkg::CNT_ONE);
                    s_next.bus_wr = !(rd_dec && (rd_left > ict_pkg::CNT_ONE));
                    if (last_bus) begin
                        s_next.bus_rd = 1'b0;
                        s_next.bus_wr = 1'b0;
                        s_next.st = int_zero ? ict_pkg::ST_IDLE : ict_pkg::ST_INT;
                        s_next.busy = !int_zero;
                        s_next.done = int_zero;
                    end
                end
            end
            ict_pkg::ST_INT: begin
                if (int_left == 10'h001) begin
                    s_next.st = ict_pkg::ST_IDLE;
                    s_next.busy = 1'b0;
                    s_next.done = 1'b1;
                end
            end
            default: s_next = RESET_S;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            s_reg <= RESET_S;
        end else begin
            s_reg <= s_next;
        end
    end

    assign busy = s_reg.busy;
    assign done = s_reg.done;
    assign fault = s_reg.fault;
    assign bus_rd = s_reg.bus_rd;
    assign bus_wr = s_reg.bus_wr;
    assign tot_clk = s_reg.tot_clk;
    assign tot_rd = s_reg.tot_rd;
    assign tot_wr = s_reg.tot_wr;

    ////////////////////////////////////////////////////////////////////////
    // checks
    property p_len;
        @(posedge clk) disable iff (srst) (done && !fault) |-> s_reg.seen_clk == tot_clk + s_reg.seen_wait;
    endproperty
    a_len: assert property (p_len) else $error("busy time differs from total");
    property p_rdcnt;
        @(posedge clk) disable iff (srst) (done && !fault) |-> s_reg.seen_rd == tot_rd && s_reg.seen_wr == tot_wr;
    endproperty
    a_rdcnt: assert property (p_rdcnt) else $error("bus cycle count differs");
    property p_excl;
        @(posedge clk) disable iff (srst) !(bus_rd && bus_wr);
    endproperty
    a_excl: assert property (p_excl) else $error("read and write together");
    property p_cyc;
        @(posedge clk) disable iff (srst) $rose(bus_wr) |-> bus_wr [*4];
    endproperty
    a_cyc: assert property (p_cyc) else $error("write cycle under four clocks");
    property p_ea;
        @(posedge clk) disable iff (srst) (take && op == ict_pkg::OP_CLEAR && mem_operand
            && size == ict_pkg::SZ_WORD) |=> tot_clk == 10'h008 + {2'h0, $past(ea_clk)};
    endproperty
    a_ea: assert property (p_ea) else $error("address time not added");
    property p_shift;
        @(posedge clk) disable iff (srst) (take && op == ict_pkg::OP_ROT && !mem_operand
            && size == ict_pkg::SZ_LONG) |=> tot_clk == 10'h008 + {3'h0, $past(shift_cnt), 1'b0};
    endproperty
    a_shift: assert property (p_shift) else $error("register shift time wrong");
    property p_mshift;
        @(posedge clk) disable iff (srst) (take && op == ict_pkg::OP_LSHIFT && mem_operand
            && size == ict_pkg::SZ_LONG) |=> fault && done && !busy;
    endproperty
    a_mshift: assert property (p_mshift) else $error("long memory shift accepted");
    property p_br;
        @(posedge clk) disable iff (srst) (take && op == ict_pkg::OP_CONDBR && cond_true)
            |=> tot_clk == 10'h00a && tot_rd == 6'h02 && tot_wr == 6'h00;
    endproperty
    a_br: assert property (p_br) else $error("taken branch figures wrong");
    property p_call;
        @(posedge clk) disable iff (srst) (take && op == ict_pkg::OP_CALLABS
            && amode == ict_pkg::AM_INDEX) |=> tot_clk == 10'h016 && tot_wr == 6'h02;
    endproperty
    a_call: assert property (p_call) else $error("indexed call figures wrong");
endmodule

/* File: sim/ict_mem_model.sv */
`timescale 1ns/1ps
// bus partner: ends each bus cycle after its fourth clock plus wait clocks
module ict_mem_model (
    input wire logic clk,
    input wire logic srst,
    input wire logic bus_rd,
    input wire logic bus_wr,
    input wire logic [1:0] waits, // wait clocks added to every bus cycle
    output logic bus_ready
);
    int ph_reg; // clock count inside the current bus cycle
    // ready only in the last clock, so a slow partner really stretches the cycle
    assign bus_ready = (bus_rd | bus_wr) && (ph_reg == 3 + int'(waits));
    always @(posedge clk) begin
        if (srst || !(bus_rd | bus_wr) || bus_ready) ph_reg <= 0;
        else ph_reg <= ph_reg + 1;
    end
endmodule

/* File: sim/cpu_instruction_cycle_timing_tb.sv */
`timescale 1ns/1ps
module cpu_instruction_cycle_timing_tb;
    logic clk = 0, srst = 1, start = 0, mem_operand, addr_reg_target, cond_true, count_expired;
    logic disp_word, bit_static, busy, done, fault, bus_rd, bus_wr, bus_ready;
    ict_pkg::ict_op_t op = ict_pkg::OP_CLEAR;
    ict_pkg::ict_size_t size = ict_pkg::SZ_BYTE;
    ict_pkg::ict_am_t amode = ict_pkg::AM_IND;
    logic [5:0] shift_cnt = 6'h00, tot_rd, tot_wr;
    logic [4:0] reg_cnt = 5'h00;
    logic [7:0] ea_clk = 8'h00;
    logic [3:0] ea_rd = 4'h0, ea_wr = 4'h0;
    logic [9:0] tot_clk;
    logic [1:0] waits = 2'h0;
    int num_errors = 0, n_tests = 0, seed = 32'ha5a241ec, n;
    initial {mem_operand, cond_true, count_expired, disp_word, bit_static, addr_reg_target} = 0;
    always #12.5 clk = ~clk;
    ict_core u_dut (.clk(clk), .srst(srst), .start(start), .op(op), .size(size),
        .mem_operand(mem_operand), .addr_reg_target(addr_reg_target), .cond_true(cond_true),
        .count_expired(count_expired), .disp_word(disp_word), .bit_static(bit_static),
        .amode(amode), .shift_cnt(shift_cnt), .reg_cnt(reg_cnt), .ea_clk(ea_clk),
        .ea_rd(ea_rd), .ea_wr(ea_wr), .bus_ready(bus_ready), .busy(busy), .done(done),
        .fault(fault), .bus_rd(bus_rd), .bus_wr(bus_wr), .tot_clk(tot_clk), .tot_rd(tot_rd),
        .tot_wr(tot_wr));
    ict_mem_model u_mem (.clk(clk), .srst(srst), .bus_rd(bus_rd), .bus_wr(bus_wr),
        .waits(waits), .bus_ready(bus_ready));
    ////////////////////////////////////////////////////////////////////////
    // compare one figure; x on the design side never matches
    task chk(input string nm, input int e, input logic [31:0] s);
        n_tests++;
        if (s !== 32'(e)) begin
            num_errors++;
            $display("Error %s expected %0d seen %0d", nm, e, s);
        end
    endtask
    // one instruction: inputs at falling edge, busy clocks counted until done
    task go(input ict_pkg::ict_op_t o, input logic [1:0] sz, input logic [5:0] f,
            input ict_pkg::ict_am_t am, input int ec, er, ew, input bit ad, fl);
        int k, nb, nr, nw;
        begin
            k = 0;
            nb = 0;
            nr = 0;
            nw = 0;
            @(negedge clk);
            op = o;
            size = ict_pkg::ict_size_t'(sz);
            {mem_operand, cond_true, count_expired, disp_word, bit_static, addr_reg_target} = f;
            amode = am;
            shift_cnt = 6'(n);
            reg_cnt = 5'(n);
            ea_rd = 4'($random(seed) & 1);
            ea_wr = 4'($random(seed) & 1);
            ea_clk = 8'(4 * (ea_rd + ea_wr) + 2 * ($random(seed) & 3));
            waits = 2'($random(seed));
            start = 1;
            @(negedge clk);
            start = 0;
            while (done !== 1'b1 && k < 2000) begin
                if (busy === 1'b1) nb++;
                if (bus_rd === 1'b1) nr++;
                if (bus_wr === 1'b1) nw++;
                @(negedge clk);
                k++;
            end
            // additive entries take the address figures each to its own total
            if (ad) begin
                ec += ea_clk;
                er += ea_rd;
                ew += ea_wr;
            end
            chk("fault", fl, fault);
            if (!fl) begin
                chk("tot_clk", ec, tot_clk);
                chk("tot_rd", er, tot_rd);
                chk("tot_wr", ew, tot_wr);
                chk("busy_clocks", ec + waits * (er + ew), nb);
                chk("read_clocks", er * (4 + waits), nr);
                chk("write_clocks", ew * (4 + waits), nw);
            end
            $display("test %s done", o.name());
        end
    endtask
    task wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // watchdog: far above the several hundred clocks the list needs
    initial begin
        #(25 * 40000);
        num_errors++;
        wrap_up;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        @(negedge clk) srst = 0;
        n = 0;
        go(ict_pkg::OP_CLEAR, 2, 6'h00, ict_pkg::AM_IND, 6, 1, 0, 0, 0);
        go(ict_pkg::OP_CLEAR, 2, 6'h20, ict_pkg::AM_IND, 12, 1, 2, 1, 0);
        go(ict_pkg::OP_TESTSET, 0, 6'h20, ict_pkg::AM_IND, 14, 2, 1, 1, 0);
        go(ict_pkg::OP_SETCOND, 0, 6'h10, ict_pkg::AM_IND, 6, 1, 0, 0, 0);
        for (int i = 8; i < 12; i++) begin
            n = $random(seed) & 7;
            go(ict_pkg::ict_op_t'(5'(i)), 2, 6'h00, ict_pkg::AM_IND, 8 + 2 * n, 1, 0, 0, 0);
        end
        go(ict_pkg::OP_ROTX, 1, 6'h20, ict_pkg::AM_IND, 8, 1, 1, 1, 0);
        go(ict_pkg::OP_LSHIFT, 2, 6'h20, ict_pkg::AM_IND, 0, 0, 0, 0, 1);
        go(ict_pkg::OP_BIT_CLEAR, 0, 6'h00, ict_pkg::AM_IND, 10, 1, 0, 0, 0);
        go(ict_pkg::OP_BIT_CLEAR, 0, 6'h02, ict_pkg::AM_IND, 14, 2, 0, 0, 0);
        go(ict_pkg::OP_BIT_SET, 0, 6'h01, ict_pkg::AM_IND, 0, 0, 0, 0, 1);
        go(ict_pkg::OP_CONDBR, 1, 6'h04, ict_pkg::AM_IND, 12, 2, 0, 0, 0);
        go(ict_pkg::OP_CALLREL, 1, 6'h00, ict_pkg::AM_IND, 18, 2, 2, 0, 0);
        go(ict_pkg::OP_DECBR, 1, 6'h08, ict_pkg::AM_IND, 14, 3, 0, 0, 0);
        go(ict_pkg::OP_CALLABS, 1, 6'h00, ict_pkg::AM_INDEX, 22, 2, 2, 0, 0);
        go(ict_pkg::OP_PUSHEA, 2, 6'h00, ict_pkg::AM_ABSL, 20, 3, 2, 0, 0);
        n = 1 + ($random(seed) & 7);
        go(ict_pkg::OP_MREG_LD, 2, 6'h00, ict_pkg::AM_DISP, 16 + 8 * n, 4 + 2 * n, 0, 0, 0);
        go(ict_pkg::OP_MREG_ST, 2, 6'h00, ict_pkg::AM_PRE, 8 + 8 * n, 2, 2 * n, 0, 0);
        go(ict_pkg::OP_CLEAR, 1, 6'h20, ict_pkg::AM_IND, 8, 1, 1, 1, 0);
        go(ict_pkg::OP_BNOT, 0, 6'h00, ict_pkg::AM_IND, 4, 1, 0, 0, 0);
        go(ict_pkg::OP_DECNEG, 0, 6'h20, ict_pkg::AM_IND, 8, 1, 1, 1, 0);
        go(ict_pkg::OP_TOZERO, 2, 6'h20, ict_pkg::AM_IND, 4, 1, 0, 1, 0);
        go(ict_pkg::OP_BTEST, 0, 6'h03, ict_pkg::AM_IND, 10, 2, 0, 0, 0);
        go(ict_pkg::OP_BTEST, 0, 6'h20, ict_pkg::AM_IND, 4, 1, 0, 1, 0);
        go(ict_pkg::OP_BTOG, 0, 6'h22, ict_pkg::AM_IND, 12, 2, 1, 1, 0);
        go(ict_pkg::OP_CONDBR, 0, 6'h10, ict_pkg::AM_IND, 10, 2, 0, 0, 0);
        go(ict_pkg::OP_GOTO, 0, 6'h00, ict_pkg::AM_IND, 10, 2, 0, 0, 0);
        go(ict_pkg::OP_BOUNDS, 1, 6'h00, ict_pkg::AM_IND, 10, 1, 0, 1, 0);
        go(ict_pkg::OP_OVFTRAP, 0, 6'h00, ict_pkg::AM_IND, 4, 1, 0, 0, 0);
        go(ict_pkg::OP_DECBR, 1, 6'h10, ict_pkg::AM_IND, 12, 2, 0, 0, 0);
        go(ict_pkg::OP_JUMP, 0, 6'h00, ict_pkg::AM_IND, 8, 2, 0, 0, 0);
        go(ict_pkg::OP_JUMP, 0, 6'h00, ict_pkg::AM_POST, 0, 0, 0, 0, 1);
        go(ict_pkg::OP_LOADEA, 0, 6'h00, ict_pkg::AM_ABSL, 12, 3, 0, 0, 0);
        wrap_up;
    end
endmodule
